// >>> hw/line_event_pkg.sv
package line_event_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ALARM_STATUS_OFFSET = 8'h19;
  localparam logic [7:0] EVENT_STATUS_SECOND_OFFSET = 8'h1A;
  localparam logic [7:0] ERROR_TALLY_LOW_BYTE_OFFSET = 8'h1B;
  localparam logic [7:0] ERROR_TALLY_HIGH_BYTE_OFFSET = 8'h1C;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int WAVEFORM_AMPLITUDE_OVERFLOW_BIT = 7;
  localparam int JITTER_BUFFER_OVERFLOW_BIT = 6;
  localparam int JITTER_BUFFER_UNDERFLOW_BIT = 5;
  localparam int PATTERN_LOGIC_ERROR_BIT = 4;
  localparam int EXCESS_ZEROS_BIT = 3;
  localparam int CODE_VIOLATION_BIT = 2;
  localparam int SECOND_TIMER_EXPIRY_BIT = 1;
  localparam int TALLY_OVERFLOW_BIT = 0;
  localparam int ALARM_FLAG_BIT = 1;
  localparam logic [7:0] EVENT_STATUS_RESET = 8'h00;
  localparam logic [15:0] ERROR_TALLY_RESET = 16'h0000;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd_en;
    logic [7:0] addr;
  } host_read_type;

  // one-cycle event pulses from the line logic, msb first as in the status byte
  typedef struct packed {
    logic waveform_amplitude_overflow;
    logic jitter_buffer_overflow;
    logic jitter_buffer_underflow;
    logic pattern_logic_error;
    logic excess_zeros;
    logic code_violation;
    logic second_timer_expiry;
  } line_event_type;

  typedef struct packed {
    logic alarm_status;
    logic alarm_interrupt_mask;
    logic alarm_edge_select;
  } alarm_ctrl_type;

endpackage : line_event_pkg

// >>> hw/error_tally_counter.sv
`timescale 1ns/100ps
`default_nettype none

module error_tally_counter #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic count_pulse,
  output logic [WIDTH-1:0] tally,
  output logic tally_overflow
);
  import line_event_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] tally;
    logic overflow;
  } tally_state_type;

  tally_state_type state_q;
  tally_state_type state_d;

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.overflow = 1'b0;
    if (count_pulse) begin
      state_d.tally = state_q.tally + {{(WIDTH-1){1'b0}}, 1'b1};
      // wraps to zero; the wrap itself is the overflow event
      state_d.overflow = &state_q.tally;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.tally <= WIDTH'(ERROR_TALLY_RESET);
      state_q.overflow <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign tally = state_q.tally;
  assign tally_overflow = state_q.overflow;

  AST_TALLY_WRAP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    count_pulse && (&tally) |=> tally_overflow && tally == '0)
    else $error("tally wrap did not flag overflow");

endmodule : error_tally_counter

`default_nettype wire

// >>> hw/line_event_status.sv
// Operation
// - reading event status returns flags, then clears them and drops their request
// - bit 7 latches waveform amplitude overflow, else zero
// - bit 6 latches jitter buffer overflow, else zero
// - bit 5 latches jitter buffer underflow, else zero
// - bit 4 latches pattern detector logic error
// - bit 3 latches excessive zeros on receive line
// - bit 2 latches received code violation
// - bit 1 latches each one-second timer expiry
// - bit 0 latches 16-bit error tally overflow
// - all eight event flags reset to zero
// - low tally byte shows counter bits 7..0, resets to zero
// - high tally byte shows counter bits 15..8, resets to zero
// - unmasked alarm interrupts on rise, or any change when edge select set
`timescale 1ns/100ps
`default_nettype none

module line_event_status (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire line_event_pkg::host_read_type host_read,
  input wire line_event_pkg::line_event_type line_events,
  input wire logic error_pulse,
  input wire line_event_pkg::alarm_ctrl_type alarm_ctrl,
  output logic [7:0] rd_data,
  output logic int_req
);
  import line_event_pkg::*;

  typedef struct packed {
    logic [7:0] event_flags;
    logic alarm_flag;
    logic alarm_prev;
    logic [7:0] rd_data;
    logic int_req;
  } status_state_type;

  status_state_type state_q;
  status_state_type state_d;
  logic [15:0] tally;
  logic tally_overflow;
  logic [7:0] event_set;
  logic alarm_event;
  logic rd_events;
  logic rd_alarm;

  // ---------------------------------------------------------------
  // error tally
  // ---------------------------------------------------------------
  error_tally_counter #(
    .WIDTH(16)
  ) u_tally (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .count_pulse(error_pulse),
    .tally(tally),
    .tally_overflow(tally_overflow)
  );

  // ---------------------------------------------------------------
  // event sources
  // ---------------------------------------------------------------
  assign event_set = {line_events, tally_overflow};
  assign rd_events = host_read.rd_en && host_read.addr == EVENT_STATUS_SECOND_OFFSET;
  assign rd_alarm = host_read.rd_en && host_read.addr == ALARM_STATUS_OFFSET;
  // the status input is taken as synchronous, so no extra stage before the compare
  assign alarm_event = !alarm_ctrl.alarm_interrupt_mask &&
    (alarm_ctrl.alarm_edge_select ? (alarm_ctrl.alarm_status != state_q.alarm_prev)
                                  : (alarm_ctrl.alarm_status && !state_q.alarm_prev));

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.alarm_prev = alarm_ctrl.alarm_status;
    // a set in the cycle of the read wins, so no event is lost
    state_d.event_flags = (rd_events ? 8'h00 : state_q.event_flags) | event_set;
    state_d.alarm_flag = (rd_alarm ? 1'b0 : state_q.alarm_flag) | alarm_event;
    state_d.rd_data = READ_DATA_RESET;
    if (host_read.rd_en) begin
      case (host_read.addr)
        EVENT_STATUS_SECOND_OFFSET: state_d.rd_data = state_q.event_flags;
        ALARM_STATUS_OFFSET: state_d.rd_data = {6'h00, state_q.alarm_flag, 1'b0};
        ERROR_TALLY_LOW_BYTE_OFFSET: state_d.rd_data = tally[7:0];
        ERROR_TALLY_HIGH_BYTE_OFFSET: state_d.rd_data = tally[15:8];
        default: state_d.rd_data = UNMAPPED_READ_VALUE;
      endcase
    end
    // flags of this byte have no mask of their own, so each one requests
    state_d.int_req = (|state_d.event_flags) || state_d.alarm_flag;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.event_flags <= EVENT_STATUS_RESET;
      state_q.alarm_flag <= 1'b0;
      state_q.alarm_prev <= 1'b0;
      state_q.rd_data <= READ_DATA_RESET;
      state_q.int_req <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign rd_data = state_q.rd_data;
  assign int_req = state_q.int_req;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_READ_RETURNS_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_events |=> rd_data == $past(state_q.event_flags))
    else $error("status read returned wrong flags");
  AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_events && event_set == 8'h00 |=> state_q.event_flags == 8'h00)
    else $error("status read did not clear flags");
  AST_WAVEFORM_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.waveform_amplitude_overflow |=> state_q.event_flags[7])
    else $error("amplitude overflow not latched");
  AST_JITTER_OVF_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.jitter_buffer_overflow |=> state_q.event_flags[6])
    else $error("jitter overflow not latched");
  AST_JITTER_UDF_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.jitter_buffer_underflow |=> state_q.event_flags[5])
    else $error("jitter underflow not latched");
  AST_PATTERN_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.pattern_logic_error |=> state_q.event_flags[4])
    else $error("pattern error not latched");
  AST_ZEROS_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.excess_zeros |=> state_q.event_flags[3])
    else $error("excess zeros not latched");
  AST_CV_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.code_violation |=> state_q.event_flags[2])
    else $error("code violation not latched");
  AST_TIMER_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_events.second_timer_expiry |=> state_q.event_flags[1])
    else $error("timer expiry not latched");
  AST_TALLY_OVF_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    error_pulse && (&tally) |=> ##1 state_q.event_flags[0])
    else $error("tally overflow not latched");
  AST_NO_SPURIOUS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !rd_events && event_set == 8'h00 |=> state_q.event_flags == $past(state_q.event_flags))
    else $error("flag changed with no cause");
  AST_TALLY_BYTES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_read.rd_en && host_read.addr == ERROR_TALLY_LOW_BYTE_OFFSET
    |=> rd_data == $past(tally[7:0]))
    else $error("low tally byte wrong");
  AST_TALLY_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_read.rd_en && host_read.addr == ERROR_TALLY_HIGH_BYTE_OFFSET
    |=> rd_data == $past(tally[15:8]))
    else $error("high tally byte wrong");
  AST_ALARM_RISE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !alarm_ctrl.alarm_interrupt_mask && $rose(alarm_ctrl.alarm_status)
    |=> state_q.alarm_flag && int_req)
    else $error("alarm rise gave no request");
  AST_REQ_FOLLOWS_FLAGS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    int_req == ((|state_q.event_flags) || state_q.alarm_flag))
    else $error("request does not follow flags");

  // ---------------------------------------------------------------
  // alarm, request, read path, tally and reset checks
  // ---------------------------------------------------------------
  // history restarts at zero, so the first edge after reset is left out
  AST_ALARM_CHANGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n) && !alarm_ctrl.alarm_interrupt_mask && alarm_ctrl.alarm_edge_select &&
    $changed(alarm_ctrl.alarm_status) |=> state_q.alarm_flag)
    else $error("alarm change gave no flag");
  AST_ALARM_MASKED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    alarm_ctrl.alarm_interrupt_mask && !state_q.alarm_flag |=> !state_q.alarm_flag)
    else $error("masked alarm raised a flag");
  AST_ALARM_READ_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_alarm |=> rd_data[ALARM_FLAG_BIT] == $past(state_q.alarm_flag))
    else $error("alarm read returned wrong flag");
  AST_ALARM_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_alarm && !alarm_event |=> !state_q.alarm_flag)
    else $error("alarm read did not clear flag");
  AST_EVENT_RAISES_REQ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    event_set != 8'h00 |=> int_req)
    else $error("event gave no request");
  AST_SET_DURING_READ: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_events |=> state_q.event_flags == $past(event_set))
    else $error("read lost a new event");
  AST_RD_DATA_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !host_read.rd_en |=> rd_data == READ_DATA_RESET)
    else $error("read data not idle");
  AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    host_read.rd_en && (host_read.addr < ALARM_STATUS_OFFSET ||
    host_read.addr > ERROR_TALLY_HIGH_BYTE_OFFSET) |=> rd_data == UNMAPPED_READ_VALUE)
    else $error("unmapped read not zero");
  AST_TALLY_STEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    error_pulse && !(&tally) |=> tally == $past(tally) + 16'h0001)
    else $error("tally did not step by one");
  AST_TALLY_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !error_pulse |=> $stable(tally))
    else $error("tally moved with no error");
  // no disable here: this one watches the reset itself
  AST_RESET_CLEARS: assert property (@(posedge ref_clk)
    !rst_n |=> state_q.event_flags == EVENT_STATUS_RESET && tally == ERROR_TALLY_RESET &&
    !int_req && rd_data == READ_DATA_RESET)
    else $error("reset left state behind");

  // ---------------------------------------------------------------
  // per-flag checks
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_flag_chk
    AST_FLAG_STICKY: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_q.event_flags[i] && !rd_events |=> state_q.event_flags[i])
      else $error("flag dropped with no read");
    AST_FLAG_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rd_events && !event_set[i] |=> !state_q.event_flags[i])
      else $error("flag survived a read");
  end

  // ---------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------
  COV_READ_WITH_FLAG: cover property (@(posedge ref_clk) disable iff (!rst_n)
    rd_events && state_q.event_flags != 8'h00);
  COV_SET_DURING_READ: cover property (@(posedge ref_clk) disable iff (!rst_n)
    rd_events && event_set != 8'h00);
  COV_TALLY_WRAP: cover property (@(posedge ref_clk) disable iff (!rst_n) tally_overflow);
  COV_ALARM_FALL: cover property (@(posedge ref_clk) disable iff (!rst_n)
    alarm_event && !alarm_ctrl.alarm_status);
  COV_MASKED_RISE: cover property (@(posedge ref_clk) disable iff (!rst_n)
    alarm_ctrl.alarm_interrupt_mask && alarm_ctrl.alarm_status && !state_q.alarm_prev);

endmodule : line_event_status

`default_nettype wire

// >>> testbench/host_model.sv
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// host processor on the control interface
// ---------------------------------------------------------------
module host_model (
  input wire logic ref_clk,
  output var line_event_pkg::host_read_type host_read,
  input wire logic [7:0] rd_data
);
  import line_event_pkg::*;

  initial host_read = '{rd_en: 1'b0, addr: 8'hFF};

  // address is inverted once released so a stale decode cannot pass
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    host_read = '{rd_en: 1'b1, addr: a};
    @(negedge ref_clk);
    d = rd_data;
    host_read = '{rd_en: 1'b0, addr: ~a};
  endtask : rd
endmodule : host_model

`default_nettype wire

// >>> testbench/line_event_status_and_error_counter_test.sv
`timescale 1ns/100ps
`default_nettype none

module line_event_status_and_error_counter_test;
  import line_event_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  line_event_type ev = '0;
  logic err = 1'b0;
  alarm_ctrl_type al = '0;
  host_read_type hr;
  logic [7:0] rd_data;
  logic int_req;
  int miscompares = 0;
  int checked = 0;

  always #50 ref_clk = ~ref_clk;

  line_event_status dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .host_read(hr),
    .line_events(ev), .error_pulse(err), .alarm_ctrl(al), .rd_data(rd_data),
    .int_req(int_req));
  host_model host_u (.ref_clk(ref_clk), .host_read(hr), .rd_data(rd_data));

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(a, d);
    cmp(d, exp);
  endtask : rchk

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic reset_test();
    rchk(EVENT_STATUS_SECOND_OFFSET, 8'h00);
    rchk(ERROR_TALLY_LOW_BYTE_OFFSET, 8'h00);
    rchk(ERROR_TALLY_HIGH_BYTE_OFFSET, 8'h00);
    rchk(8'h20, 8'h00);
    cmp({7'h00, int_req}, 8'h00);
    $display("reset test done");
  endtask : reset_test

  task automatic event_test();
    for (int i = 0; i < 7; i++) begin
      @(negedge ref_clk);
      ev = line_event_type'(7'h01 << i);
      @(negedge ref_clk);
      ev = '0;
      cmp({7'h00, int_req}, 8'h01);
      rchk(EVENT_STATUS_SECOND_OFFSET, 8'h02 << i);
      rchk(EVENT_STATUS_SECOND_OFFSET, 8'h00);
      cmp({7'h00, int_req}, 8'h00);
    end
    // an event in the very cycle of the read must survive the clear
    fork
      rchk(EVENT_STATUS_SECOND_OFFSET, 8'h00);
      begin
        @(negedge ref_clk);
        ev.code_violation = 1'b1;
        @(negedge ref_clk);
        ev = '0;
      end
    join
    rchk(EVENT_STATUS_SECOND_OFFSET, 8'h04);
    cmp({7'h00, int_req}, 8'h00);
    $display("event test done");
  endtask : event_test

  // the full wrap costs 65536 cycles, the bulk of the run
  task automatic tally_test();
    @(negedge ref_clk);
    err = 1'b1;
    repeat (291) @(negedge ref_clk);
    err = 1'b0;
    rchk(ERROR_TALLY_LOW_BYTE_OFFSET, 8'h23);
    rchk(ERROR_TALLY_HIGH_BYTE_OFFSET, 8'h01);
    err = 1'b1;
    repeat (65245) @(negedge ref_clk);
    err = 1'b0;
    repeat (2) @(negedge ref_clk);
    cmp({7'h00, int_req}, 8'h01);
    rchk(EVENT_STATUS_SECOND_OFFSET, 8'h01);
    rchk(ERROR_TALLY_LOW_BYTE_OFFSET, 8'h00);
    rchk(ERROR_TALLY_HIGH_BYTE_OFFSET, 8'h00);
    $display("tally test done");
  endtask : tally_test

  task automatic alarm_step(input alarm_ctrl_type a, input logic exp);
    @(negedge ref_clk);
    al = a;
    repeat (2) @(negedge ref_clk);
    cmp({7'h00, int_req}, {7'h00, exp});
    rchk(ALARM_STATUS_OFFSET, {6'h00, exp, 1'b0});
  endtask : alarm_step

  task automatic alarm_test();
    alarm_step('{1'b1, 1'b0, 1'b0}, 1'b1);
    alarm_step('{1'b0, 1'b0, 1'b0}, 1'b0);
    alarm_step('{1'b1, 1'b0, 1'b1}, 1'b1);
    alarm_step('{1'b0, 1'b0, 1'b1}, 1'b1);
    alarm_step('{1'b1, 1'b1, 1'b1}, 1'b0);
    $display("alarm test done");
  endtask : alarm_test

  // flags and tally are loaded first so that the reset has something to clear
  task automatic reset_again_test();
    @(negedge ref_clk);
    ev = '1;
    err = 1'b1;
    @(negedge ref_clk);
    ev = '0;
    err = 1'b0;
    cmp({7'h00, int_req}, 8'h01);
    rst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_n = 1'b1;
    reset_test();
    $display("second reset test done");
  endtask : reset_again_test

  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    reset_test();
    event_test();
    alarm_test();
    reset_again_test();
    tally_test();
    stop_test();
  end

  // expected run is about 66000 cycles
  initial begin
    #9000000;
    miscompares++;
    stop_test();
  end
endmodule : line_event_status_and_error_counter_test

`default_nettype wire
